// file: common/wkr_access_if.sv
// Purpose: Carries one decoded management access from the serial front end to the bank
// Assumes: Single clock domain
// Notes:   Strobes are one cycle wide
`timescale 1ns/1ps
`default_nettype none
interface wkr_access_if;
    logic        wr_stb;
    logic        rd_stb;
    logic [4:0]  reg_addr;
    logic [15:0] wr_data;
    logic [15:0] rd_data;

    modport front (
        output wr_stb,
        output rd_stb,
        output reg_addr,
        output wr_data,
        input  rd_data
    );
    modport bank (
        input  wr_stb,
        input  rd_stb,
        input  reg_addr,
        input  wr_data,
        output rd_data
    );
endinterface : wkr_access_if
`default_nettype wire

// file: common/wkr_defs.svh
// Purpose: Constants for the wake register bank (offsets, fields, resets, codes)
// Assumes: Included by bare name from design and testbench files
// Notes:   Definitions only
`ifndef WKR_DEFS_SVH
`define WKR_DEFS_SVH

`define WKR_WAKE_PAGE        16'h0320
`define WKR_PAGE_REG_ADDR    5'h1F
`define WKR_PHY_REG_MAX      5'h0F
`define WKR_INSTR_ADDR_SET   5'h11
`define WKR_INSTR_DATA_CYCLE 5'h12
`define WKR_OP_WRITE         2'h1
`define WKR_OP_READ          2'h2

`define WKR_REG_RX_CTRL      16'h0000
`define WKR_REG_WAKE_CTRL    16'h0001
`define WKR_REG_FILT_CTRL    16'h0002

`define WKR_RX_CTRL_RESET    16'h0004
`define WKR_RX_CTRL_MASK     16'h01FF
`define WKR_WAKE_CTRL_RESET  16'h0000
`define WKR_WAKE_CTRL_MASK   16'hC03F
`define WKR_FILT_CTRL_RESET  16'h0000

`define WKR_RX_UPE_BIT       0
`define WKR_RX_MPE_BIT       1
`define WKR_RX_SLAVE_BIT     2
`define WKR_RX_MO_LSB        3
`define WKR_RX_BAM_BIT       5
`define WKR_RX_PASS_CONTROL_FRAMES_BIT      6
`define WKR_RX_RX_FLOW_CONTROL_ENABLE_BIT      7

`define WKR_WU_POWER_MGMT_WAKE_ENABLE_BIT      0
`define WKR_WU_ACPI_BIT      1
`define WKR_WU_STATUS_BIT    2
`define WKR_WU_ENERGY_BIT    3
`define WKR_WU_LINK_CHANGE_WAKE_ENABLE_BIT     4
`define WKR_WU_LINK_CHANGE_WAKE_OVERRIDE_BIT     5
`define WKR_WU_FLEX_FILTER_SIX_ENABLE_BIT      14
`define WKR_WU_FLEX_FILTER_SEVEN_ENABLE_BIT      15
`define WKR_FC_LINK_BIT      0

`define WKR_MDIO_TA_CYCLES   2

`endif

// file: common/wkr_pkg.sv
// Purpose: Types for the wake register bank
// Assumes: wkr_defs.svh holds the numbers
// Notes:   None
package wkr_pkg;
    typedef enum logic [2:0] {
        WKR_IDLE,
        WKR_PREAMBLE,
        WKR_HEADER,
        WKR_TURN,
        WKR_DATA,
        WKR_DONE
    } wkr_frame_state_t;

    typedef logic [1:0] wkr_op_t;
endpackage : wkr_pkg

// file: src/wkr_bank.sv
// Purpose: Wake-up register bank behind the management serial interface
// Assumes: Management frames arrive on mdc_i/mdio_i; por_n_i is the power-on reset
// Notes:   phy_reset_i clears nothing in the wake bank
`timescale 1ns/1ps
`default_nettype none
`include "wkr_defs.svh"
module wkr_bank
    import wkr_pkg::*;
#(
    parameter logic [4:0] PHY_ADDR = 5'h01
) (
    input  wire logic        clock_i,
    input  wire logic        resetn_i,
    input  wire logic        por_n_i,
    input  wire logic        phy_reset_i,
    input  wire logic        mdc_i,
    input  wire logic        mdio_i,
    output logic             mdio_o,
    output logic             mdio_oe_o,
    output logic             ready_o,
    output logic             phy_reg_wr_o,
    output logic             phy_reg_rd_o,
    output logic [3:0]       phy_reg_addr_o,
    output logic [15:0]      phy_reg_wdata_o,
    input  wire logic [15:0] phy_reg_rdata_i,
    input  wire logic        wake_event_i,
    input  wire logic        host_wake_active_clr_i,
    input  wire logic        mgmt_engine_wake_active_clr_i,
    input  wire logic        link_change_i,
    input  wire logic        energy_detect_i,
    input  wire logic        autoneg_enable_i,
    input  wire logic        autoneg_duplex_i,
    input  wire logic [47:0] dest_addr_i,
    output logic             wake_page_active_o,
    output logic             unicast_promisc_enable_o,
    output logic             multicast_promisc_enable_o,
    output logic             filters_active_o,
    output logic [9:0]       multicast_index_o,
    output logic             broadcast_accept_o,
    output logic             pass_control_frames_o,
    output logic             rx_flow_control_enable_o,
    output logic             power_mgmt_wake_enable_o,
    output logic             acpi_wake_enable_o,
    output logic             wake_event_status_o,
    output logic             flex_filter_six_enable_o,
    output logic             flex_filter_seven_enable_o,
    output logic             link_change_wake_o
);
    // ****************************************
    // Serial front end
    // ****************************************
    wkr_access_if acc ();

    wkr_mdio_front #(
        .PHY_ADDR (PHY_ADDR)
    ) u_front (
        .clock_i   (clock_i),
        .resetn_i  (resetn_i),
        .mdc_i     (mdc_i),
        .mdio_i    (mdio_i),
        .mdio_o    (mdio_o),
        .mdio_oe_o (mdio_oe_o),
        .ready_o   (ready_o),
        .acc       (acc)
    );

    // ****************************************
    // Input synchronisers
    // ****************************************
    logic [1:0] por_sync_q;
    logic [1:0] evt_sync_q;
    logic [1:0] hclr_sync_q;
    logic [1:0] mclr_sync_q;
    logic [1:0] link_sync_q;
    logic [1:0] energy_sync_q;
    logic       evt_last_q;
    logic       link_last_q;
    logic       energy_last_q;

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            evt_sync_q    <= 2'h0;
            hclr_sync_q   <= 2'h0;
            mclr_sync_q   <= 2'h0;
            link_sync_q   <= 2'h0;
            energy_sync_q <= 2'h0;
            evt_last_q    <= 1'b0;
            link_last_q   <= 1'b0;
            energy_last_q <= 1'b0;
        end else begin
            evt_sync_q    <= {evt_sync_q[0], wake_event_i};
            hclr_sync_q   <= {hclr_sync_q[0], host_wake_active_clr_i};
            mclr_sync_q   <= {mclr_sync_q[0], mgmt_engine_wake_active_clr_i};
            link_sync_q   <= {link_sync_q[0], link_change_i};
            energy_sync_q <= {energy_sync_q[0], energy_detect_i};
            evt_last_q    <= evt_sync_q[1];
            link_last_q   <= link_sync_q[1];
            energy_last_q <= energy_sync_q[1];
        end
    end

    // Power-on sync has no resetn_i branch, so a block reset cannot clear the wake registers or ind_addr_q
    always_ff @(posedge clock_i) begin
        por_sync_q <= {por_sync_q[0], por_n_i};
    end

    logic por_active;
    logic wake_evt;
    logic wake_clr;
    assign por_active = ~por_sync_q[1];
    assign wake_evt   = evt_sync_q[1] & ~evt_last_q;
    assign wake_clr   = hclr_sync_q[1] | mclr_sync_q[1];

    // ****************************************
    // Page tracking and instruction decode
    // ****************************************
    logic [15:0] page_q;
    logic [15:0] ind_addr_q;
    logic        wake_mode;
    logic        hi_addr;
    logic        data_wr;
    logic        data_rd;

    assign wake_mode = page_q == `WKR_WAKE_PAGE;
    assign hi_addr   = acc.reg_addr > `WKR_PHY_REG_MAX;
    assign data_wr   = wake_mode && acc.wr_stb && acc.reg_addr == `WKR_INSTR_DATA_CYCLE;
    assign data_rd   = wake_mode && acc.reg_addr == `WKR_INSTR_DATA_CYCLE;

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            page_q <= 16'h0000;
        end else if (acc.wr_stb && acc.reg_addr == `WKR_PAGE_REG_ADDR) begin
            page_q <= acc.wr_data;
        end
    end

    // Survives resetn_i and phy_reset_i alike
    always_ff @(posedge clock_i) begin
        if (por_active) begin
            ind_addr_q <= 16'h0000;
        end else if (wake_mode && acc.wr_stb && acc.reg_addr == `WKR_INSTR_ADDR_SET) begin
            ind_addr_q <= acc.wr_data;
        end
    end

    // ****************************************
    // Wake registers
    // ****************************************
    logic [15:0] rx_ctrl_q;
    logic [15:0] wake_ctrl_q;
    logic [15:0] filt_ctrl_q;

    // Set to reset values only by power-on reset, never by resetn_i or phy_reset_i
    always_ff @(posedge clock_i) begin
        if (por_active) begin
            rx_ctrl_q <= `WKR_RX_CTRL_RESET;
        end else if (data_wr && ind_addr_q == `WKR_REG_RX_CTRL) begin
            rx_ctrl_q <= acc.wr_data & `WKR_RX_CTRL_MASK;
        end else if (autoneg_enable_i) begin
            rx_ctrl_q[`WKR_RX_RX_FLOW_CONTROL_ENABLE_BIT] <= autoneg_duplex_i;
        end
    end

    always_ff @(posedge clock_i) begin
        if (por_active) begin
            wake_ctrl_q <= `WKR_WAKE_CTRL_RESET;
        end else begin
            if (data_wr && ind_addr_q == `WKR_REG_WAKE_CTRL) begin
                wake_ctrl_q <= (acc.wr_data & `WKR_WAKE_CTRL_MASK &
                                ~(16'h0001 << `WKR_WU_STATUS_BIT))
                             | (wake_ctrl_q & (16'h0001 << `WKR_WU_STATUS_BIT));
                if (acc.wr_data[`WKR_WU_STATUS_BIT]) begin
                    wake_ctrl_q[`WKR_WU_STATUS_BIT] <= 1'b0;
                end
            end
            if (wake_clr) begin
                wake_ctrl_q[`WKR_WU_STATUS_BIT] <= 1'b0;
            end
            if (wake_evt) begin
                wake_ctrl_q[`WKR_WU_STATUS_BIT] <= 1'b1;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (por_active) begin
            filt_ctrl_q <= `WKR_FILT_CTRL_RESET;
        end else if (data_wr && ind_addr_q == `WKR_REG_FILT_CTRL) begin
            filt_ctrl_q <= acc.wr_data;
        end
    end

    // ****************************************
    // Read path
    // ****************************************
    always_comb begin
        if (!hi_addr) begin
            acc.rd_data = phy_reg_rdata_i;
        end else if (!wake_mode) begin
            acc.rd_data = (acc.reg_addr == `WKR_PAGE_REG_ADDR) ? page_q : 16'h0000;
        end else if (data_rd) begin
            case (ind_addr_q)
                `WKR_REG_RX_CTRL:   acc.rd_data = rx_ctrl_q;
                `WKR_REG_WAKE_CTRL: acc.rd_data = wake_ctrl_q;
                `WKR_REG_FILT_CTRL: acc.rd_data = filt_ctrl_q;
                default:            acc.rd_data = 16'h0000;
            endcase
        end else if (acc.reg_addr == `WKR_PAGE_REG_ADDR) begin
            acc.rd_data = page_q;
        end else begin
            acc.rd_data = 16'h0000;
        end
    end

    // Ordinary PHY registers pass straight through
    assign phy_reg_wr_o    = acc.wr_stb && !hi_addr;
    assign phy_reg_rd_o    = acc.rd_stb && !hi_addr;
    assign phy_reg_addr_o  = acc.reg_addr[3:0];
    assign phy_reg_wdata_o = acc.wr_data;

    // ****************************************
    // Control outputs
    // ****************************************
    function automatic logic [9:0] mc_index(input logic [1:0] sel, input logic [47:0] da);
        case (sel)
            2'h0:    mc_index = da[47:38];
            2'h1:    mc_index = da[46:37];
            2'h2:    mc_index = da[45:36];
            default: mc_index = da[43:34];
        endcase
    endfunction : mc_index

    logic link_cond;
    logic link_enable;
    assign link_cond = wake_ctrl_q[`WKR_WU_ENERGY_BIT]
                     ? (energy_sync_q[1] & ~energy_last_q)
                     : (link_sync_q[1] ^ link_last_q);
    assign link_enable = wake_ctrl_q[`WKR_WU_LINK_CHANGE_WAKE_OVERRIDE_BIT]
                       ? (wake_ctrl_q[`WKR_WU_POWER_MGMT_WAKE_ENABLE_BIT] & wake_ctrl_q[`WKR_WU_LINK_CHANGE_WAKE_ENABLE_BIT])
                       : filt_ctrl_q[`WKR_FC_LINK_BIT];

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            link_change_wake_o <= 1'b0;
            multicast_index_o  <= 10'h000;
        end else begin
            link_change_wake_o <= link_cond & link_enable;
            multicast_index_o  <= mc_index(rx_ctrl_q[`WKR_RX_MO_LSB +: 2], dest_addr_i);
        end
    end

    assign wake_page_active_o         = wake_mode;
    assign unicast_promisc_enable_o   = rx_ctrl_q[`WKR_RX_UPE_BIT];
    assign multicast_promisc_enable_o = rx_ctrl_q[`WKR_RX_MPE_BIT];
    assign filters_active_o           = ~rx_ctrl_q[`WKR_RX_SLAVE_BIT];
    assign broadcast_accept_o         = rx_ctrl_q[`WKR_RX_BAM_BIT];
    assign pass_control_frames_o      = rx_ctrl_q[`WKR_RX_PASS_CONTROL_FRAMES_BIT];
    assign rx_flow_control_enable_o   = rx_ctrl_q[`WKR_RX_RX_FLOW_CONTROL_ENABLE_BIT];
    assign power_mgmt_wake_enable_o   = wake_ctrl_q[`WKR_WU_POWER_MGMT_WAKE_ENABLE_BIT];
    assign acpi_wake_enable_o         = wake_ctrl_q[`WKR_WU_ACPI_BIT];
    assign wake_event_status_o        = wake_ctrl_q[`WKR_WU_STATUS_BIT];
    assign flex_filter_six_enable_o   = wake_ctrl_q[`WKR_WU_FLEX_FILTER_SIX_ENABLE_BIT];
    assign flex_filter_seven_enable_o = wake_ctrl_q[`WKR_WU_FLEX_FILTER_SEVEN_ENABLE_BIT];

    logic unused_phy_reset;
    assign unused_phy_reset = phy_reset_i;
endmodule : wkr_bank
`default_nettype wire

// file: src/wkr_mdio_front.sv
// Purpose: Management serial slave: samples clock and data pins, decodes frames
// Assumes: Link clock far slower than clock_i; pins pass two flip-flops first
// Notes:   Read data shifts after falling edges of the link clock; the first bit follows the rise ending turnaround
`timescale 1ns/1ps
`default_nettype none
`include "wkr_defs.svh"
module wkr_mdio_front
    import wkr_pkg::*;
#(
    parameter logic [4:0] PHY_ADDR = 5'h01
) (
    input  wire logic   clock_i,
    input  wire logic   resetn_i,
    input  wire logic   mdc_i,
    input  wire logic   mdio_i,
    output logic        mdio_o,
    output logic        mdio_oe_o,
    output logic        ready_o,
    wkr_access_if.front acc
);
    // ****************************************
    // Pin synchronisers and edge detect
    // ****************************************
    logic [1:0] mdc_sync_q;
    logic [1:0] mdio_sync_q;
    logic       mdc_last_q;
    logic       rise;
    logic       fall;

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            mdc_sync_q  <= 2'h0;
            mdio_sync_q <= 2'h3;
            mdc_last_q  <= 1'b0;
        end else begin
            mdc_sync_q  <= {mdc_sync_q[0], mdc_i};
            mdio_sync_q <= {mdio_sync_q[0], mdio_i};
            mdc_last_q  <= mdc_sync_q[1];
        end
    end
    assign rise = mdc_sync_q[1] & ~mdc_last_q;
    assign fall = ~mdc_sync_q[1] & mdc_last_q;

    // ****************************************
    // Frame decoder
    // ****************************************
    wkr_frame_state_t state_q;
    logic [5:0]       cnt_q;
    logic [13:0]      hdr_q;
    logic [15:0]      shift_q;
    logic             mine_q;
    logic             is_read_q;

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            state_q   <= WKR_IDLE;
            cnt_q     <= 6'h00;
            hdr_q     <= 14'h0000;
            shift_q   <= 16'h0000;
            mine_q    <= 1'b0;
            is_read_q <= 1'b0;
            ready_o   <= 1'b0;
        end else begin
            acc.wr_stb <= 1'b0;
            acc.rd_stb <= 1'b0;
            if (rise) begin
                case (state_q)
                    WKR_IDLE: begin
                        if (!mdio_sync_q[1]) begin
                            state_q <= WKR_HEADER;
                            cnt_q   <= 6'h00;
                            ready_o <= 1'b0;
                        end
                    end
                    WKR_HEADER: begin
                        hdr_q <= {hdr_q[12:0], mdio_sync_q[1]};
                        cnt_q <= cnt_q + 6'h01;
                        if (cnt_q == 6'h0C) begin
                            state_q   <= WKR_TURN;
                            cnt_q     <= 6'h00;
                            mine_q    <= hdr_q[8:4] == PHY_ADDR;
                            is_read_q <= {hdr_q[10:9]} == `WKR_OP_READ;
                            acc.reg_addr <= {hdr_q[3:0], mdio_sync_q[1]};
                            acc.rd_stb <= (hdr_q[10:9] == `WKR_OP_READ)
                                          && (hdr_q[8:4] == PHY_ADDR);
                        end
                    end
                    WKR_TURN: begin
                        cnt_q <= cnt_q + 6'h01;
                        if (cnt_q == 6'(`WKR_MDIO_TA_CYCLES - 1)) begin
                            state_q <= WKR_DATA;
                            cnt_q   <= 6'h00;
                            shift_q <= acc.rd_data;
                        end
                    end
                    WKR_DATA: begin
                        cnt_q   <= cnt_q + 6'h01;
                        if (!is_read_q) begin
                            shift_q <= {shift_q[14:0], mdio_sync_q[1]};
                        end
                        if (cnt_q == 6'h0F) begin
                            state_q <= WKR_IDLE;
                            ready_o <= mine_q;
                            if (mine_q && !is_read_q) begin
                                acc.wr_stb  <= 1'b1;
                                acc.wr_data <= {shift_q[14:0], mdio_sync_q[1]};
                            end
                        end
                    end
                    default: state_q <= WKR_IDLE;
                endcase
            end else if (fall && state_q == WKR_DATA && is_read_q && cnt_q != 6'h00) begin
                shift_q <= {shift_q[14:0], 1'b0};
            end
        end
    end

    // Start of frame: 01 after idle ones; header holds start lsb, op, phy, reg
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            mdio_o    <= 1'b1;
            mdio_oe_o <= 1'b0;
        end else begin
            mdio_oe_o <= mine_q && is_read_q &&
                         (state_q == WKR_DATA || (state_q == WKR_TURN && cnt_q == 6'h01));
            mdio_o    <= (state_q == WKR_DATA) ? shift_q[15] : 1'b0;
        end
    end
endmodule : wkr_mdio_front
`default_nettype wire

// file: testbench/wkr_bank_asserts.sv
// Purpose: Port checks for the wake register bank
// Assumes: One clock domain
// Notes:   Bound to wkr_bank
`timescale 1ns/1ps
`default_nettype none
module wkr_bank_asserts (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic por_n_i,
    input wire logic mdio_o,
    input wire logic mdio_oe_o,
    input wire logic ready_o,
    input wire logic phy_reg_wr_o,
    input wire logic wake_event_i,
    input wire logic host_wake_active_clr_i,
    input wire logic autoneg_enable_i,
    input wire logic autoneg_duplex_i,
    input wire logic wake_page_active_o,
    input wire logic unicast_promisc_enable_o,
    input wire logic filters_active_o,
    input wire logic rx_flow_control_enable_o,
    input wire logic power_mgmt_wake_enable_o,
    input wire logic wake_event_status_o,
    input wire logic link_change_wake_o
);
    default clocking @(posedge clock_i);
    endclocking
    default disable iff (!resetn_i || !por_n_i);
    chk_reset_idle_pins: assert property (disable iff (1'b0)
        !resetn_i |=> !mdio_oe_o && mdio_o && !ready_o) else $error("pins not idle in reset");
    chk_ready_after_write: assert property (
        phy_reg_wr_o |-> ##[0:4] ready_o) else $error("ready missing after write");
    chk_page_sets_ready: assert property (
        $rose(wake_page_active_o) |-> ##[0:4] ready_o) else $error("page change without ready");
    chk_status_sets: assert property (
        $rose(wake_event_i) |-> ##[1:6] wake_event_status_o) else $error("status not set");
    chk_status_clears: assert property (
        (host_wake_active_clr_i && !wake_event_i) [*6] |-> !wake_event_status_o)
        else $error("status not cleared");
    chk_duplex_follow: assert property (
        (autoneg_enable_i && $stable(autoneg_duplex_i)) [*3]
        |-> rx_flow_control_enable_o == autoneg_duplex_i) else $error("flow bit not duplex");
    chk_link_one_pulse: assert property (
        link_change_wake_o |=> !link_change_wake_o) else $error("link wake pulse too long");
    chk_por_defaults: assert property (disable iff (1'b0)
        (!por_n_i) [*6] |-> !unicast_promisc_enable_o && !filters_active_o
        && !power_mgmt_wake_enable_o && !wake_event_status_o) else $error("power-on defaults");
endmodule : wkr_bank_asserts
bind wkr_bank wkr_bank_asserts i_chk (.clock_i(clock_i), .resetn_i(resetn_i),
    .por_n_i(por_n_i), .mdio_o(mdio_o), .mdio_oe_o(mdio_oe_o), .ready_o(ready_o),
    .phy_reg_wr_o(phy_reg_wr_o), .wake_event_i(wake_event_i),
    .host_wake_active_clr_i(host_wake_active_clr_i), .autoneg_enable_i(autoneg_enable_i),
    .autoneg_duplex_i(autoneg_duplex_i), .wake_page_active_o(wake_page_active_o),
    .unicast_promisc_enable_o(unicast_promisc_enable_o), .filters_active_o(filters_active_o),
    .rx_flow_control_enable_o(rx_flow_control_enable_o),
    .power_mgmt_wake_enable_o(power_mgmt_wake_enable_o),
    .wake_event_status_o(wake_event_status_o), .link_change_wake_o(link_change_wake_o));
`default_nettype wire

// file: testbench/wkr_bank_test.sv
// Purpose: Self-checking bench for the wake register bank
// Assumes: Host model on the management pins
// Notes:   None
`timescale 1ns/1ps
`default_nettype none
`include "wkr_defs.svh"
module wkr_bank_test;
    logic clock_i = 0, resetn_i = 0, por_n_i = 0, prst = 0, wev = 0, hclr = 0, mclr = 0;
    logic lnk = 0, en = 0, an = 0, dup = 0, mdc, line, mo, moe, rdy, pwr, lw;
    logic [15:0] prd = 16'hBEEF, pd, x;
    logic [3:0] pa, pa_q;
    logic [47:0] da = 48'hA5C3_9F17_E24B;
    logic [9:0] mi;
    wire  [5:0] rx;
    wire  [3:0] wu;
    logic st, wpg, fa;
    int err_total = 0, comparisons = 0, lw_cnt = 0;
    always #25 clock_i = ~clock_i;
    wkr_host_model i_host (.mdc_o(mdc), .line_o(line), .dut_oe_i(moe), .dut_d_i(mo));
    wkr_bank i_dut (.clock_i(clock_i), .resetn_i(resetn_i), .por_n_i(por_n_i),
        .phy_reset_i(prst), .mdc_i(mdc), .mdio_i(line), .mdio_o(mo), .mdio_oe_o(moe),
        .ready_o(rdy), .phy_reg_wr_o(pwr), .phy_reg_rd_o(), .phy_reg_addr_o(pa),
        .phy_reg_wdata_o(pd), .phy_reg_rdata_i(prd), .wake_event_i(wev),
        .host_wake_active_clr_i(hclr), .mgmt_engine_wake_active_clr_i(mclr),
        .link_change_i(lnk), .energy_detect_i(en), .autoneg_enable_i(an),
        .autoneg_duplex_i(dup), .dest_addr_i(da), .wake_page_active_o(wpg),
        .unicast_promisc_enable_o(rx[5]), .multicast_promisc_enable_o(rx[4]),
        .filters_active_o(fa), .multicast_index_o(mi), .broadcast_accept_o(rx[2]),
        .pass_control_frames_o(rx[1]), .rx_flow_control_enable_o(rx[0]),
        .power_mgmt_wake_enable_o(wu[3]), .acpi_wake_enable_o(wu[2]),
        .wake_event_status_o(st), .flex_filter_six_enable_o(wu[1]),
        .flex_filter_seven_enable_o(wu[0]), .link_change_wake_o(lw));
    assign rx[3] = fa;
    always @(posedge clock_i) if (pwr === 1'b1) pa_q <= pa;
    always @(posedge clock_i) if (lw === 1'b1) lw_cnt++;
    task chk(input string n, input logic [15:0] s, input logic [15:0] e);
        comparisons++;
        if (s !== e) begin
            err_total++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task wr(input logic [4:0] r, input logic [15:0] d, input logic [4:0] p = 5'h01);
        @(posedge clock_i) #2;
        i_host.xfer(`WKR_OP_WRITE, p, r, d, x);
        chk("ready", rdy, p == 5'h01);
    endtask : wr
    task rd(input logic [4:0] r, input logic [15:0] e);
        @(posedge clock_i) #2;
        i_host.xfer(`WKR_OP_READ, 5'h01, r, 16'h0000, x);
        chk("read", x, e);
    endtask : rd
    task wreg(input logic [15:0] a, input logic [15:0] d);
        wr(`WKR_INSTR_ADDR_SET, a);
        wr(`WKR_INSTR_DATA_CYCLE, d);
    endtask : wreg
    task rreg(input logic [15:0] a, input logic [15:0] e);
        wr(`WKR_INSTR_ADDR_SET, a);
        rd(`WKR_INSTR_DATA_CYCLE, e);
    endtask : rreg
    task link_try(input logic [15:0] v, input logic use_energy, input int exp);
        wreg(16'h0001, v);
        lw_cnt = 0;
        @(posedge clock_i) #2 if (use_energy) en = 1; else lnk = ~lnk;
        repeat (12) @(posedge clock_i);
        en = 0;
        chk("link wake", lw_cnt, exp);
    endtask : link_try
    task tally_and_finish;
        $display("Checks %0d, mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish
    initial begin
        #2_000_000 err_total++;
        tally_and_finish();
    end
    initial begin
        repeat (2) @(posedge clock_i);
        #2 resetn_i = 1;
        repeat (6) @(posedge clock_i);
        #2 por_n_i = 1;
        repeat (8) @(posedge clock_i);
        wr(`WKR_PAGE_REG_ADDR, `WKR_WAKE_PAGE);
        chk("page", wpg, 1);
        rreg(16'h0000, `WKR_RX_CTRL_RESET);
        rreg(16'h0001, 16'h0000);
        $display("Test defaults done");
        wreg(16'h0000, 16'hFFFF);
        rreg(16'h0000, 16'h01FF);
        chk("rx outs", rx, 6'h37);
        an = 1;
        repeat (6) @(posedge clock_i);
        chk("flow", rx[0], 0);
        an = 0;
        for (int m = 0; m < 4; m++) begin
            wreg(16'h0000, m << 3);
            chk("mc index", mi, m == 3 ? da[43:34] : da[47 - m -: 10]);
        end
        chk("filters", fa, 1);
        wreg(16'h0001, 16'hFFFF);
        rreg(16'h0001, 16'hC03B);
        chk("wake outs", wu, 4'hF);
        for (int k = 0; k < 3; k++) begin
            @(posedge clock_i) #2 wev = 1;
            repeat (6) @(posedge clock_i) #2 wev = 0;
            chk("status set", st, 1);
            if (k == 0) wreg(16'h0001, 16'hC03F);
            hclr = k == 1;
            mclr = k == 2;
            repeat (8) @(posedge clock_i);
            #2 {hclr, mclr} = 0;
            chk("status clear", st, 0);
        end
        link_try(16'h0031, 0, 1);
        link_try(16'h0011, 0, 0);
        wreg(16'h0002, 16'h0001);
        link_try(16'h0011, 0, 1);
        link_try(16'h0039, 1, 1);
        $display("Test wake control done");
        wr(5'h05, 16'h1234);
        chk("phy wr", {pa_q, pd}, 20'h51234);
        rd(5'h03, 16'hBEEF);
        wr(5'h13, 16'hFFFF);
        rd(5'h13, 16'h0000);
        wr(`WKR_INSTR_DATA_CYCLE, 16'h0000, 5'h02);
        rreg(16'h0000, 16'h0018);
        @(posedge clock_i) #2 {prst, resetn_i} = 2'b10;
        repeat (2) @(posedge clock_i);
        #2 {prst, resetn_i} = 2'b01;
        repeat (4) @(posedge clock_i);
        chk("page off", wpg, 0);
        wr(`WKR_PAGE_REG_ADDR, `WKR_WAKE_PAGE);
        rreg(16'h0000, 16'h0018);
        por_n_i = 0;
        repeat (8) @(posedge clock_i);
        #2 por_n_i = 1;
        repeat (4) @(posedge clock_i);
        rreg(16'h0000, `WKR_RX_CTRL_RESET);
        $display("Test pass-through and resets done");
        tally_and_finish();
    end
endmodule : wkr_bank_test
`default_nettype wire

// file: testbench/wkr_host_model.sv
// Purpose: Controller model sending management frames
// Assumes: Data line pulled up when nobody drives it
// Notes:   Link clock stands low between frames
`timescale 1ns/1ps
`default_nettype none
module wkr_host_model (
    output logic     mdc_o,
    output logic     line_o,
    input wire logic dut_oe_i,
    input wire logic dut_d_i
);
    logic drv = 1'b0;
    logic bit_q = 1'b1;
    initial mdc_o = 1'b0;
    assign line_o = dut_oe_i ? dut_d_i : (drv ? bit_q : 1'b1);
    task xfer(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
              input logic [15:0] wd, output logic [15:0] rd);
        logic [31:0] f;
        f = {4'h5 ^ {2'b00, op ^ 2'b01}, pa, ra, 2'b10, wd};
        for (int i = 31; i >= 0; i--) begin
            mdc_o = 1'b0;
            drv = !(op == `WKR_OP_READ && i < 18);
            bit_q = f[i];
            #200;
            mdc_o = 1'b1;
            if (i < 16) rd[i] = line_o;
            #200;
        end
        mdc_o = 1'b0;
        drv = 1'b0;
        #800;
    endtask : xfer
endmodule : wkr_host_model
`default_nettype wire
